// [test/fpc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fpc_host_model (
  input  wire logic       sys_clk,       // Bus clock
  input  wire logic [7:0] rdata,         // Read data
  output var  logic       chip_select_n, // Select, low
  output var  logic       rd_n,          // Read strobe
  output var  logic       wr_n,          // Write strobe
  output var  logic [2:0] addr,          // Port offset
  output var  logic [7:0] wdata          // Write data
);
  // Idle bus at time zero
  initial begin
    chip_select_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 3'h0;
    wdata = 8'h00;
  end
  // Strobe held two edges; released lines flip so stale data never matches
  task automatic access(input logic w, input logic [2:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk);
    chip_select_n <= 1'b0;
    addr <= a;
    wdata <= d;
    rd_n <= w;
    wr_n <= !w;
    repeat (2) @(posedge sys_clk);
    q = rdata;
    chip_select_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    addr <= ~a;
    wdata <= ~d;
    @(posedge sys_clk);
  endtask
  // Key writes back to back, nothing in between
  task automatic unlock;
    logic [7:0] q;
    access(1'b1, 3'h0, 8'h55, q);
    access(1'b1, 3'h0, 8'h55, q);
  endtask
endmodule
`default_nettype wire

// [test/fpc_power_config_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module fpc_power_config_monitor (
  input wire logic       sys_clk,           // Clock
  input wire logic       reset,             // Reset
  input wire logic       chip_select_n,     // Select
  input wire logic       rd_n,              // Read
  input wire logic       wr_n,              // Write
  input wire logic [2:0] addr,              // Offset
  input wire logic [7:0] wdata,             // Data in
  input wire logic       rdata_oe,          // Bus drive
  input wire logic       core_int,          // Core irq
  input wire logic       step_in,           // Core step
  input wire logic [1:0] rate_in,           // Core rate
  input wire logic       dir_step_in,       // Core direction
  input wire logic       head_in,           // Core head
  input wire logic       dens_in,           // Core density
  input wire logic       direction_out,     // Direction pin
  input wire logic       head_select_out,   // Head pin
  input wire logic       density_out,       // Density pin
  input wire logic [3:0] drive_select_oe,   // Select drive
  input wire logic       step_out,          // Step pin
  input wire logic [1:0] rate_outs,         // Rate pins
  input wire logic [3:0] motor_enable_outs, // Motor pins
  input wire logic [3:0] motor_enable_oe,   // Motor drive
  input wire logic       write_data_oe,     // Wdata drive
  input wire logic       write_gate_oe,     // Wgate drive
  input wire logic       irq_out,           // Irq pin
  input wire logic       dma_request_out,   // Dma pin
  input wire logic       soft_reset_pulse,  // Soft reset
  input wire logic       auto_pd_reg,       // Auto pd
  input wire logic       low_power_reg,     // Any pd
  input wire logic       config_mode_reg    // Config mode
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  // Selected strobe qualifier
  wire logic sel;
  assign sel = !chip_select_n;
  property p_pass;
    !$past(reset) |-> step_out == $past(step_in) && rate_outs == $past(rate_in)
      && direction_out == $past(dir_step_in)
      && head_select_out == $past(head_in)
      && density_out == $past(dens_in);
  endproperty
  a_pass: assert property (p_pass) else $error("drive pin lost");
  property p_tri;
    low_power_reg && $past(low_power_reg) |-> motor_enable_oe == 4'h0 &&
      drive_select_oe == 4'h0 && !write_data_oe && !write_gate_oe;
  endproperty
  a_tri: assert property (p_tri) else $error("drive not tristated");
  property p_host;
    low_power_reg && $past(low_power_reg) |-> !irq_out && !dma_request_out;
  endproperty
  a_host: assert property (p_host) else $error("request high in pd");
  property p_msr;
    auto_pd_reg && sel && $fell(rd_n) && addr == 3'h4 |-> ##[1:3] !auto_pd_reg;
  endproperty
  a_msr: assert property (p_msr) else $error("status read no wake");
  property p_fifo;
    auto_pd_reg && sel && ($fell(rd_n) || $fell(wr_n)) && addr == 3'h5
      |-> ##[1:3] !auto_pd_reg;
  endproperty
  a_fifo: assert property (p_fifo) else $error("fifo access no wake");
  property p_cond;
    $rose(auto_pd_reg) |-> motor_enable_outs == 4'h0 && !$past(core_int, 2);
  endproperty
  a_cond: assert property (p_cond) else $error("pd while busy");
  property p_dsr;
    sel && $fell(wr_n) && addr == 3'h4 && wdata[7] |-> ##[1:2] soft_reset_pulse;
  endproperty
  a_dsr: assert property (p_dsr) else $error("no soft reset");
  property p_pulse;
    soft_reset_pulse |=> !soft_reset_pulse;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long soft reset");
  property p_exit;
    config_mode_reg && sel && $fell(wr_n) && addr == 3'h0 && wdata == 8'haa
      |-> ##[1:2] !config_mode_reg;
  endproperty
  a_exit: assert property (p_exit) else $error("exit key ignored");
  property p_enter;
    $rose(config_mode_reg) |-> $past(wdata) == 8'h55 || $past(wdata, 2) == 8'h55;
  endproperty
  a_enter: assert property (p_enter) else $error("entry without key");
  property p_oe;
    rdata_oe |-> !$past(rd_n) || !$past(rd_n, 2);
  endproperty
  a_oe: assert property (p_oe) else $error("bus driven unread");
endmodule
`default_nettype wire

// [test/test_fpc_power_config.sv]
`timescale 1ns/1ps
`default_nettype none
module test_fpc_power_config;
  localparam int IDLE = 40;
  localparam logic [7:0] PID = 8'h3c; // Arbitrary identity value
  localparam logic [7:0] PRV = 8'h07; // Arbitrary revision value
  logic            sys_clk = 1'b0;
  logic            reset = 1'b1;
  logic            power_on = 1'b1;
  logic      [7:0] msr_in = 8'h80;
  logic      [7:0] dir_in = 8'h00;
  logic      [7:0] drv = 8'h00;
  logic            core_drq = 1'b0;
  logic            core_int = 1'b0;
  logic      [7:0] q;
  int              miscompares = 0;
  int              check_count = 0;
  int              cyc = 0;
  wire logic       chip_select_n, rd_n, wr_n;
  wire logic [2:0] addr;
  wire logic [7:0] wdata, rdata, dtype;
  wire logic       auto_pd, low_pwr, cfg_mode, dma_req;
  always #10 sys_clk = ~sys_clk;
  fpc_host_model HOST (.sys_clk(sys_clk), .rdata(rdata),
    .chip_select_n(chip_select_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
    .wdata(wdata));
  // Head timer tied expired so powerdown can be reached
  fpc_power_config #(.IDLE_CYCLES(IDLE), .PART_ID(PID), .PART_REV(PRV)) DUT (
    .sys_clk(sys_clk), .reset(reset), .power_on(power_on),
    .chip_select_n(chip_select_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
    .wdata(wdata), .rdata(rdata), .rdata_oe(), .msr_in(msr_in),
    .fifo_in(drv), .dir_in(dir_in), .core_int(core_int), .core_drq(core_drq),
    .head_unloaded(1'b1), .step_in(drv[0]), .dir_step_in(drv[1]),
    .head_in(drv[2]), .dens_in(drv[3]), .rate_in(drv[5:4]),
    .wdat_in(drv[6]), .wgate_in(drv[7]), .motor_enable_outs(),
    .motor_enable_oe(), .drive_select_outs(), .drive_select_oe(),
    .write_data_out(), .write_data_oe(), .write_gate_out(),
    .write_gate_oe(), .step_out(), .direction_out(), .head_select_out(),
    .density_out(), .rate_outs(), .irq_out(), .dma_request_out(dma_req),
    .soft_reset_pulse(), .auto_pd_reg(auto_pd), .low_power_reg(low_pwr),
    .config_mode_reg(cfg_mode), .cfg_extdrv_reg(), .cfg_dtype_reg(dtype),
    .cfg_rate_reg(), .cfg_kind_reg());
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Random core drive levels and hang guard
  always @(posedge sys_clk) begin
    drv <= 8'($urandom);
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      miscompares++;
      $display("[FAIL] %0t timeout", $time);
      complete_run();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic flag(input logic g, input logic e, input string m);
    chk({7'h00, g}, {7'h00, e}, m);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    HOST.access(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [2:0] a);
    HOST.access(1'b0, a, 8'h00, q);
  endtask
  task automatic cfg_wr(input logic [7:0] i, input logic [7:0] d);
    wr(3'h0, i);
    wr(3'h1, d);
  endtask
  task automatic cfg_rd(input logic [7:0] i);
    wr(3'h0, i);
    rd(3'h1);
  endtask
  // Bounded wait on the powerdown flag
  task automatic wait_pd(input logic v, input int n, input string m);
    for (int k = 0; k < n && auto_pd !== v; k++) @(posedge sys_clk);
    flag(auto_pd, v, m);
  endtask
  function automatic logic [7:0] exp_cr(input int i);
    case (i)
      0: return 8'h28;
      1: return 8'h90;
      3: return 8'h70;
      6: return 8'hff;
      13: return PID;
      14: return PRV;
      default: return 8'h00;
    endcase
  endfunction
  task automatic hw_reset;
    @(posedge sys_clk);
    reset <= 1'b1;
    @(posedge sys_clk);
    reset <= 1'b0;
  endtask
  // Main sequence
  initial begin
    logic [7:0] v;
    logic [7:0] d6;
    void'($urandom(32'h5a99f7f1));
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    power_on <= 1'b0;
    rd(3'h1);
    chk(q, 8'h00, "data port before unlock");
    wr(3'h0, 8'h55);
    wr(3'h2, 8'h04);
    wr(3'h0, 8'h55);
    flag(cfg_mode, 1'b0, "split unlock");
    HOST.unlock();
    flag(cfg_mode, 1'b1, "unlock");
    for (int i = 0; i < 32; i++) begin
      cfg_rd(8'(i));
      chk(q, exp_cr(i), "default");
    end
    d6 = 8'($urandom);
    cfg_wr(8'h06, d6);
    chk(dtype, d6, "drive_type_table pins");
    v = 8'($urandom);
    cfg_wr(8'h05, v);
    cfg_rd(8'h05);
    chk(q, v & 8'h7c, "extended_drive_setup mask");
    cfg_wr(8'h0d, v);
    cfg_rd(8'h0d);
    chk(q, PID, "id read only");
    cfg_wr(8'h00, 8'h20);
    flag(low_pwr, 1'b1, "direct pd");
    cfg_wr(8'h00, 8'h28);
    flag(low_pwr, 1'b0, "direct wake");
    wr(3'h0, 8'haa);
    flag(cfg_mode, 1'b0, "exit");
    hw_reset();
    chk(dtype, d6, "drive_type_table kept");
    $display("config tests done");
    wr(3'h2, 8'h04);
    HOST.unlock();
    cfg_wr(8'h07, 8'h80);
    wr(3'h0, 8'haa);
    repeat (IDLE - 10) @(posedge sys_clk);
    flag(auto_pd, 1'b0, "full count");
    wait_pd(1'b1, 20, "auto pd");
    core_drq <= 1'b1;
    dir_in <= v;
    rd(3'h7);
    chk(q, v, "dir in pd");
    flag(dma_req, 1'b0, "dma low");
    wr(3'h4, 8'h02);
    wr(3'h2, 8'h04);
    flag(auto_pd, 1'b1, "quiet writes");
    rd(3'h4);
    chk(q, 8'h80, "status");
    wait_pd(1'b0, 4, "status wake");
    repeat (IDLE - 15) @(posedge sys_clk);
    rd(3'h4);
    repeat (IDLE - 10) @(posedge sys_clk);
    flag(auto_pd, 1'b0, "restart");
    wait_pd(1'b1, 20, "pd again");
    wr(3'h5, v);
    wait_pd(1'b0, 4, "fifo wake");
    wait_pd(1'b1, IDLE + 10, "pd after fifo");
    wr(3'h2, 8'h14);
    wait_pd(1'b0, 4, "motor wake");
    repeat (IDLE + 10) @(posedge sys_clk);
    flag(auto_pd, 1'b0, "motor on");
    wr(3'h2, 8'h04);
    wait_pd(1'b1, IDLE + 10, "motor off");
    wr(3'h4, 8'h40);
    flag(low_pwr, 1'b1, "rate pd");
    wr(3'h4, 8'h80);
    flag(low_pwr, 1'b0, "soft reset wake");
    core_int <= 1'b1;
    repeat (IDLE + 10) @(posedge sys_clk);
    flag(auto_pd, 1'b0, "interrupt pending");
    core_int <= 1'b0;
    wait_pd(1'b1, IDLE + 10, "auto resumes");
    HOST.unlock();
    cfg_wr(8'h07, 8'h00);
    repeat (IDLE + 10) @(posedge sys_clk);
    flag(auto_pd, 1'b0, "auto disabled");
    cfg_wr(8'h07, 8'h80);
    cfg_wr(8'h01, 8'h00);
    cfg_rd(8'h06);
    chk(q, 8'h00, "locked");
    hw_reset();
    HOST.unlock();
    cfg_rd(8'h01);
    chk(q, 8'h90, "lock restored");
    cfg_rd(8'h07);
    chk(q, 8'h00, "enable cleared");
    $display("power tests done");
    complete_run();
  end
endmodule
bind fpc_power_config fpc_power_config_monitor MON (.*);
`default_nettype wire

// [verilog/fpc_consts.vh]
`ifndef FPC_CONSTS_VH
`define FPC_CONSTS_VH
// Host port offsets
`define FPC_PORT_INDEX    3'h0
`define FPC_PORT_DATA     3'h1
`define FPC_PORT_DOR      3'h2
`define FPC_PORT_MSR      3'h4
`define FPC_PORT_FIFO     3'h5
`define FPC_PORT_DIR      3'h7
// Unlock and exit keys, highest config index
`define FPC_KEY_ENTER     8'h55
`define FPC_KEY_EXIT      8'haa
`define FPC_INDEX_MAX     8'h1f
// Configuration register indices
`define FPC_CR_POWER      5'h00
`define FPC_CR_LOCK       5'h01
`define FPC_CR_IFMODE     5'h03
`define FPC_CR_EXTDRV     5'h05
`define FPC_CR_DTYPE      5'h06
`define FPC_CR_AUTOPWR    5'h07
`define FPC_CR_RATETBL    5'h0b
`define FPC_CR_PARTID     5'h0d
`define FPC_CR_PARTREV    5'h0e
`define FPC_CR_KIND       5'h1f
// Power-up defaults
`define FPC_DEF_POWER     8'h28
`define FPC_DEF_LOCK      8'h90
`define FPC_DEF_IFMODE    8'h70
`define FPC_DEF_DTYPE     8'hff
`define FPC_DEF_ZERO      8'h00
// Writable masks
`define FPC_MASK_POWER    8'hac
`define FPC_MASK_IFMODE   8'h72
`define FPC_MASK_EXTDRV   8'h7c
`define FPC_MASK_AUTOPWR  8'h8f
// Field positions
`define FPC_BIT_CTRL_PWR  3
`define FPC_BIT_APD_EN    7
`define FPC_BIT_LOCK      7
`define FPC_BIT_DSR_PD    6
`define FPC_BIT_DSR_RST   7
`define FPC_BIT_DOR_RST_N 2
// Idle status value
`define FPC_MSR_IDLE      8'h80
// Idle interval
`define FPC_IDLE_MS       10
`define FPC_CLK_HZ        50000000
`define FPC_IDLE_CYCLES   ((`FPC_CLK_HZ / 1000) * `FPC_IDLE_MS)
`endif

// [verilog/fpc_power_config.v]
`timescale 1ns/1ps
`default_nettype none
`include "fpc_consts.vh"
module fpc_power_config #(
  parameter [31:0] IDLE_CYCLES = `FPC_IDLE_CYCLES, // Idle interval in cycles
  parameter [7:0]  PART_ID     = 8'h5a,  // Arbitrary identity value
  parameter [7:0]  PART_REV    = 8'h01   // Arbitrary revision value
) (
  input  wire       sys_clk,          // 50 MHz clock
  input  wire       reset,            // Hardware reset pin, active high
  input  wire       power_on,         // Power-up reset, active high
  input  wire       chip_select_n,    // Chip select, active low
  input  wire       rd_n,             // Read strobe, active low
  input  wire       wr_n,             // Write strobe, active low
  input  wire [2:0] addr,             // Port offset
  input  wire [7:0] wdata,            // Host write data
  output reg  [7:0] rdata,            // Host read data
  output reg        rdata_oe,         // High while driving data bus
  input  wire [7:0] msr_in,           // Main status from command engine
  input  wire [7:0] fifo_in,          // FIFO read data from core
  input  wire [7:0] dir_in,           // Digital input value
  input  wire       core_int,         // Core interrupt level
  input  wire       core_drq,         // Core DMA request level
  input  wire       head_unloaded,    // Head unload timer expired
  input  wire       step_in,          // Core step
  input  wire       dir_step_in,      // Core direction
  input  wire       head_in,          // Core head select
  input  wire       dens_in,          // Core density select
  input  wire [1:0] rate_in,          // Core rate bits
  input  wire       wdat_in,          // Core write data
  input  wire       wgate_in,         // Core write enable
  output reg  [3:0] motor_enable_outs,// Motor enables
  output reg  [3:0] motor_enable_oe,  // Motor enable drive
  output reg  [3:0] drive_select_outs,// Drive selects
  output reg  [3:0] drive_select_oe,  // Drive select drive
  output reg        write_data_out,   // Write data
  output reg        write_data_oe,    // Write data drive
  output reg        write_gate_out,   // Write enable
  output reg        write_gate_oe,    // Write enable drive
  output reg        step_out,         // Step, always active
  output reg        direction_out,    // Direction, always active
  output reg        head_select_out,  // Head select, always active
  output reg        density_out,      // Density select, always active
  output reg  [1:0] rate_outs,        // Rate outputs, always active
  output reg        irq_out,          // Interrupt request
  output reg        dma_request_out,  // DMA request
  output reg        soft_reset_pulse, // Software reset to core
  output reg        auto_pd_reg,      // Auto powerdown state
  output reg        low_power_reg,    // Any low power state
  output reg        config_mode_reg,  // Configuration mode active
  output reg  [7:0] cfg_extdrv_reg,   // Extended drive setup
  output reg  [7:0] cfg_dtype_reg,    // Drive type table
  output reg  [7:0] cfg_rate_reg,     // Drive rate table
  output reg  [7:0] cfg_kind_reg      // Drive kind table
);
  localparam ST_RUN  = 3'b001;
  localparam ST_AUTO = 3'b010;
  localparam ST_DSR  = 3'b100;

  reg  [2:0]  state_reg;
  reg  [7:0]  dor_reg;
  reg  [7:0]  cfg_power_reg;
  reg  [7:0]  cfg_lock_reg;
  reg  [7:0]  cfg_ifmode_reg;
  reg  [7:0]  cfg_auto_reg;
  reg  [4:0]  index_reg;
  reg         key_seen_reg;
  reg  [31:0] idle_cnt_reg;
  reg         idle_done_reg;
  reg         rd_d_reg;
  reg         wr_d_reg;
  reg         apd_en_d_reg;

  // Single strobe per host cycle: act on the falling edge of the strobe
  wire cs      = ~chip_select_n;
  wire rd_edge = cs & ~rd_n & ~rd_d_reg;
  wire wr_edge = cs & ~wr_n & ~wr_d_reg;
  wire apd_en  = cfg_auto_reg[`FPC_BIT_APD_EN];
  wire lock_ok = cfg_lock_reg[`FPC_BIT_LOCK];
  wire idx_wr  = wr_edge & (addr == `FPC_PORT_INDEX);
  wire dat_acc = cs & (addr == `FPC_PORT_DATA) & config_mode_reg &
                 lock_ok;
  wire dsr_wr  = wr_edge & (addr == `FPC_PORT_MSR);
  wire dor_wr  = wr_edge & (addr == `FPC_PORT_DOR);
  wire soft_rst = (dsr_wr & wdata[`FPC_BIT_DSR_RST]) |
                  (dor_wr & ~wdata[`FPC_BIT_DOR_RST_N]);
  // Waking accesses; plain DRIVE_OUTPUT_REG/DSR writes and other ports do not wake
  wire wake = (dor_wr & |wdata[7:4]) | soft_rst |
              (rd_edge & (addr == `FPC_PORT_MSR)) |
              ((rd_edge | wr_edge) & (addr == `FPC_PORT_FIFO));
  wire touch = (rd_edge & (addr == `FPC_PORT_MSR)) |
               ((rd_edge | wr_edge) & (addr == `FPC_PORT_FIFO));
  wire idle_ok = apd_en & (dor_reg[7:4] == 4'h0) &
                 (msr_in == `FPC_MSR_IDLE) & ~core_int &
                 head_unloaded & idle_done_reg;
  wire direct_lp = ~cfg_power_reg[`FPC_BIT_CTRL_PWR];
  wire pd_now = (state_reg != ST_RUN) | direct_lp;
  wire [7:0] cfg_rd;

  // Strobe history for edge detection
  always @(posedge sys_clk) begin
    if (reset) begin
      rd_d_reg <= 1'b0;
      wr_d_reg <= 1'b0;
    end else begin
      rd_d_reg <= cs & ~rd_n;
      wr_d_reg <= cs & ~wr_n;
    end
  end

  // Unlock, index and exit sequencing; any other write breaks the pair
  always @(posedge sys_clk) begin
    if (reset) begin
      config_mode_reg <= 1'b0;
      key_seen_reg    <= 1'b0;
      index_reg       <= 5'h00;
    end else if (idx_wr) begin
      if (!config_mode_reg) begin
        if (wdata == `FPC_KEY_ENTER) begin
          key_seen_reg    <= ~key_seen_reg;
          config_mode_reg <= key_seen_reg;
        end else begin
          key_seen_reg <= 1'b0;
        end
      end else if (wdata == `FPC_KEY_EXIT) begin
        config_mode_reg <= 1'b0;
      end else if (wdata <= `FPC_INDEX_MAX) begin
        index_reg <= wdata[4:0];
      end
    end else if (wr_edge) begin
      key_seen_reg <= 1'b0;
    end
  end

  // Configuration registers: full defaults at power-up only; the reset pin restores the lock and auto enable bits
  always @(posedge sys_clk) begin
    if (power_on) begin
      cfg_power_reg  <= `FPC_DEF_POWER;
      cfg_lock_reg   <= `FPC_DEF_LOCK;
      cfg_ifmode_reg <= `FPC_DEF_IFMODE;
      cfg_extdrv_reg <= `FPC_DEF_ZERO;
      cfg_dtype_reg  <= `FPC_DEF_DTYPE;
      cfg_auto_reg   <= `FPC_DEF_ZERO;
      cfg_rate_reg   <= `FPC_DEF_ZERO;
      cfg_kind_reg   <= `FPC_DEF_ZERO;
    end else if (reset) begin
      // Only the lock and auto enable bits react to the reset pin
      cfg_lock_reg[`FPC_BIT_LOCK]   <= 1'b1;
      cfg_auto_reg[`FPC_BIT_APD_EN] <= 1'b0;
    end else if (dat_acc & wr_edge) begin
      case (index_reg)
        `FPC_CR_POWER:
          cfg_power_reg <= wdata & `FPC_MASK_POWER;
        `FPC_CR_LOCK:
          cfg_lock_reg <= {wdata[7] & lock_ok, 7'h10};
        `FPC_CR_IFMODE:
          cfg_ifmode_reg <= wdata & `FPC_MASK_IFMODE;
        `FPC_CR_EXTDRV:
          cfg_extdrv_reg <= wdata & `FPC_MASK_EXTDRV;
        `FPC_CR_DTYPE:
          cfg_dtype_reg <= wdata;
        `FPC_CR_AUTOPWR:
          cfg_auto_reg <= wdata & `FPC_MASK_AUTOPWR;
        `FPC_CR_RATETBL:
          cfg_rate_reg <= wdata;
        `FPC_CR_KIND:
          cfg_kind_reg <= wdata;
        default:
          cfg_kind_reg <= cfg_kind_reg;                  // Reserved: ignore
      endcase
    end
  end

  // Configuration read mux; reserved and test registers read zero
  assign cfg_rd = (index_reg == `FPC_CR_POWER)   ? cfg_power_reg  :
                  (index_reg == `FPC_CR_LOCK)    ? cfg_lock_reg   :
                  (index_reg == `FPC_CR_IFMODE)  ? cfg_ifmode_reg :
                  (index_reg == `FPC_CR_EXTDRV)  ? cfg_extdrv_reg :
                  (index_reg == `FPC_CR_DTYPE)   ? cfg_dtype_reg  :
                  (index_reg == `FPC_CR_AUTOPWR) ? cfg_auto_reg   :
                  (index_reg == `FPC_CR_RATETBL) ? cfg_rate_reg   :
                  (index_reg == `FPC_CR_PARTID)  ? PART_ID        :
                  (index_reg == `FPC_CR_PARTREV) ? PART_REV       :
                  (index_reg == `FPC_CR_KIND)    ? cfg_kind_reg   :
                  `FPC_DEF_ZERO;

  // Drive output register: served even while powered down
  always @(posedge sys_clk) begin
    if (reset)
      dor_reg <= 8'h00;
    else if (dor_wr)
      dor_reg <= wdata;
  end

  // Host read data; config data only in unlocked config mode
  always @(posedge sys_clk) begin
    if (reset) begin
      rdata    <= 8'h00;
      rdata_oe <= 1'b0;
    end else begin
      rdata_oe <= cs & ~rd_n & (addr != `FPC_PORT_INDEX);
      case (addr)
        `FPC_PORT_DATA: rdata <= dat_acc ? cfg_rd : 8'h00;
        `FPC_PORT_DOR:  rdata <= dor_reg;
        `FPC_PORT_MSR:  rdata <= msr_in;
        `FPC_PORT_FIFO: rdata <= fifo_in;
        `FPC_PORT_DIR:  rdata <= dir_in;
        default:        rdata <= 8'h00;
      endcase
    end
  end

  // Idle counter counts up from zero; any restart forces a full fresh count
  always @(posedge sys_clk) begin
    if (reset) begin
      idle_cnt_reg  <= 32'h00000000;
      idle_done_reg <= 1'b0;
      apd_en_d_reg  <= 1'b0;
    end else begin
      apd_en_d_reg <= apd_en;
      if (!apd_en) begin
        idle_cnt_reg  <= 32'h00000000;
        idle_done_reg <= 1'b0;
      end else if ((apd_en & ~apd_en_d_reg) | touch | wake) begin
        idle_cnt_reg  <= 32'h00000000;
        idle_done_reg <= 1'b0;
      end else if (idle_cnt_reg >= IDLE_CYCLES - 32'h1) begin
        idle_done_reg <= 1'b1;
      end else begin
        idle_cnt_reg <= idle_cnt_reg + 32'h1;
      end
    end
  end

  // Power state machine; reset wake restarts the core, access wake keeps it
  always @(posedge sys_clk) begin
    if (reset) begin
      state_reg        <= ST_RUN;
      soft_reset_pulse <= 1'b0;
    end else begin
      soft_reset_pulse <= soft_rst;
      case (state_reg)
        ST_RUN: begin
          if (dsr_wr & wdata[`FPC_BIT_DSR_PD] & ~soft_rst)
            state_reg <= ST_DSR;
          else if (idle_ok & ~wake & ~touch)
            state_reg <= ST_AUTO;
        end
        ST_AUTO: begin
          if (dsr_wr & wdata[`FPC_BIT_DSR_PD] & ~soft_rst)
            state_reg <= ST_DSR;
          else if (wake | ~apd_en)
            state_reg <= ST_RUN;
        end
        ST_DSR: begin
          // Leaving rate-select powerdown re-arms the auto conditions
          if (soft_rst)
            state_reg <= ST_RUN;
        end
        default: state_reg <= ST_RUN;
      endcase
    end
  end

  // Drive pins: motor, select, write lines released in powerdown
  always @(posedge sys_clk) begin
    if (reset) begin
      motor_enable_outs <= 4'h0;
      motor_enable_oe   <= 4'h0;
      drive_select_outs <= 4'h0;
      drive_select_oe   <= 4'h0;
      write_data_out    <= 1'b0;
      write_data_oe     <= 1'b0;
      write_gate_out    <= 1'b0;
      write_gate_oe     <= 1'b0;
      step_out          <= 1'b0;
      direction_out     <= 1'b0;
      head_select_out   <= 1'b0;
      density_out       <= 1'b0;
      rate_outs         <= 2'b00;
      irq_out           <= 1'b0;
      dma_request_out   <= 1'b0;
      auto_pd_reg       <= 1'b0;
      low_power_reg     <= 1'b0;
    end else begin
      motor_enable_outs <= dor_reg[7:4];
      motor_enable_oe   <= {4{~pd_now}};
      drive_select_outs <= 4'h1 << dor_reg[1:0];
      drive_select_oe   <= {4{~pd_now}};
      write_data_out    <= wdat_in;
      write_data_oe     <= ~pd_now;
      write_gate_out    <= wgate_in & ~pd_now;
      write_gate_oe     <= ~pd_now;
      step_out          <= step_in;
      direction_out     <= dir_step_in;
      head_select_out   <= head_in;
      density_out       <= dens_in;
      rate_outs         <= rate_in;
      irq_out           <= core_int & ~pd_now;
      dma_request_out   <= core_drq & ~pd_now;
      auto_pd_reg       <= (state_reg == ST_AUTO);
      low_power_reg     <= pd_now;
    end
  end
endmodule
`default_nettype wire
